// File: pdr_pkg.sv
package pdr_pkg;

	// Bank geometry
	localparam int NPORT = 9;

	// Register offsets, ports 1-4, 10-12, 14, 15
	localparam logic [15:0] OFF_PORT1_DIR  = 16'hff21;
	localparam logic [15:0] OFF_PORT2_DIR  = 16'hff22;
	localparam logic [15:0] OFF_PORT3_DIR  = 16'hff23;
	localparam logic [15:0] OFF_PORT4_DIR  = 16'hff24;
	localparam logic [15:0] OFF_PORT10_DIR = 16'hff2a;
	localparam logic [15:0] OFF_PORT11_DIR = 16'hff2b;
	localparam logic [15:0] OFF_PORT12_DIR = 16'hff2c;
	localparam logic [15:0] OFF_PORT14_DIR = 16'hff2e;
	localparam logic [15:0] OFF_PORT15_DIR = 16'hff2f;

	localparam logic [NPORT-1:0][15:0] OFFSETS = {
		OFF_PORT15_DIR, OFF_PORT14_DIR, OFF_PORT12_DIR, OFF_PORT11_DIR, OFF_PORT10_DIR,
		OFF_PORT4_DIR, OFF_PORT3_DIR, OFF_PORT2_DIR, OFF_PORT1_DIR};

	// Implemented bit positions per port, others are fixed ones
	localparam logic [NPORT-1:0][7:0] IMPL_MASKS = {
		8'h0f, 8'h0f, 8'h01, 8'h0c, 8'h03, 8'h01, 8'h1e, 8'h3f, 8'h0c};

	// Value after reset: every pin an input
	localparam logic [7:0] DIR_RESET = 8'hff;

	// Answer to a read of an unmapped address
	localparam logic [7:0] UNMAPPED_DATA = 8'h00;

	// CPU memory access toward the bank
	typedef struct packed {
		logic [15:0] addr;
		logic        rd;
		logic        wr_byte;
		logic        wr_bit;
		logic [2:0]  bit_sel;
		logic        bit_val;
		logic [7:0]  wdata;
	} pdr_req_t;

	// Force unimplemented positions to one
	function automatic logic [7:0] pdr_fix(input logic [7:0] v, input logic [7:0] impl);
		return (v & impl) | ~impl;
	endfunction

endpackage

// File: pdr_dir_reg.sv
`timescale 1ns/1ps

// One port direction byte with fixed-one unimplemented bits
module pdr_dir_reg #(
	parameter logic [7:0] IMPL = 8'hff
) (
	input  wire logic             clk,
	input  wire logic             resetn,
	input  wire logic             ce,
	input  wire logic             sel,
	input  wire pdr_pkg::pdr_req_t req,
	output logic [7:0]            q
);

	logic [7:0] q_nxt;

	// Byte write replaces, bit write touches one position
	always_comb
	begin
		q_nxt = q;
		if (req.wr_byte)
			q_nxt = req.wdata; // RL2
		else if (req.wr_bit)
			q_nxt[req.bit_sel] = req.bit_val; // RL2
	end

	// Direction flops, one per pin
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			q <= pdr_pkg::DIR_RESET; // RL3
		else if (ce && sel)
			q <= pdr_pkg::pdr_fix(q_nxt, IMPL); // RL10
	end

endmodule // pdr_dir_reg

// File: pdr_port_dir.sv
`timescale 1ns/1ps

// How it works
// RL1: Every implemented pin has own direction bit
// RL2: Byte write or single-bit write supported
// RL3: Reset loads all direction registers with ones
// RL4: One selects input, output buffer off
// RL5: Zero selects output, buffer drives latch value
// RL6: Software writes ones to unused ports 1-3
// RL7: Software keeps unused bits ports 4,10,12
// RL8: Software keeps unused bits ports 11,14,15
// RL9: Software sets direction before alternate function
// RL10: Unimplemented bits are constant ones
module pdr_port_dir (
	input  wire logic                             clk,
	input  wire logic                             resetn,
	input  wire logic                             ce,
	input  wire pdr_pkg::pdr_req_t                req,
	output logic [7:0]                            rdata_r,
	output logic                                  rvalid_r,
	output logic                                  rhit_r,
	output logic [pdr_pkg::NPORT-1:0][7:0]        pin_oe_n
);

	logic [pdr_pkg::NPORT-1:0]      sel;
	logic [7:0]                     rdata_nxt;
	logic                           rhit_nxt;

	// Address decode, one byte register per port
	genvar gi;
	generate
		for (gi = 0; gi < pdr_pkg::NPORT; gi++)
		begin : g_port
			assign sel[gi] = (req.addr == pdr_pkg::OFFSETS[gi]);

			// Direction bit is the active-low output enable of each pin
			pdr_dir_reg #(
				.IMPL (pdr_pkg::IMPL_MASKS[gi])
			) u_reg (
				.clk    (clk),
				.resetn (resetn),
				.ce     (ce),
				.sel    (sel[gi]),
				.req    (req),
				.q      (pin_oe_n[gi]) // RL1 RL4 RL5
			);
		end
	endgenerate

	// Read mux, unmapped addresses answer zero
	always_comb
	begin
		rdata_nxt = pdr_pkg::UNMAPPED_DATA;
		rhit_nxt  = 1'b0;
		for (int i = 0; i < pdr_pkg::NPORT; i++)
		begin
			if (sel[i])
			begin
				rdata_nxt = pin_oe_n[i];
				rhit_nxt  = 1'b1;
			end
		end
	end

	// Registered read answer, one cycle after the strobe
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			rdata_r  <= 8'h00;
			rvalid_r <= 1'b0;
			rhit_r   <= 1'b0;
		end
		else if (ce)
		begin
			rvalid_r <= req.rd;
			if (req.rd)
			begin
				rdata_r <= rdata_nxt;
				rhit_r  <= rhit_nxt;
			end
		end
	end

	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	reset_all_ones_a: assert property (disable iff (1'b0) $rose(resetn) |-> pin_oe_n == {pdr_pkg::NPORT{8'hff}}) // RL3
		else $error("direction bank not all ones after reset");

	generate
		for (gi = 0; gi < pdr_pkg::NPORT; gi++)
		begin : g_chk
			unimpl_fixed_a: assert property ((pin_oe_n[gi] | pdr_pkg::IMPL_MASKS[gi]) == 8'hff) // RL10
				else $error("unimplemented direction bit not one");

			byte_write_a: assert property (ce && sel[gi] && req.wr_byte |=>
				pin_oe_n[gi] == pdr_pkg::pdr_fix($past(req.wdata), pdr_pkg::IMPL_MASKS[gi])) // RL2
				else $error("byte write not stored");

			bit_write_a: assert property (ce && sel[gi] && !req.wr_byte && req.wr_bit |=>
				((pin_oe_n[gi] ^ $past(pin_oe_n[gi])) & ~(8'h01 << $past(req.bit_sel))) == 8'h00) // RL2
				else $error("bit write disturbed another bit");

			port_isolate_a: assert property (!(ce && sel[gi] && (req.wr_byte || req.wr_bit)) |=>
				$stable(pin_oe_n[gi])) // RL1
				else $error("direction changed without own write");
		end
	endgenerate

	input_mode_a: assert property (ce && sel[0] && !req.wr_byte && req.wr_bit && req.bit_val
		&& req.bit_sel == 3'h2 |=> pin_oe_n[0][2]) // RL4
		else $error("pin not placed in input mode");

	output_mode_a: assert property (ce && sel[0] && !req.wr_byte && req.wr_bit && !req.bit_val
		&& req.bit_sel == 3'h3 |=> !pin_oe_n[0][3]) // RL5
		else $error("pin not placed in output mode");

	read_back_a: assert property (ce && req.rd |=> rvalid_r && rdata_r == $past(rdata_nxt)
		&& rhit_r == $past(|sel))
		else $error("read answer wrong");

	freeze_a: assert property (!ce |=> $stable(pin_oe_n) && $stable(rdata_r))
		else $error("state moved while clock enable low");

	byte_write_c: cover property (ce && sel[1] && req.wr_byte);
	bit_clear_c: cover property (ce && sel[7] && req.wr_bit && !req.wr_byte && !req.bit_val);
	unmapped_read_c: cover property (ce && req.rd && !(|sel));

endmodule // pdr_port_dir

// File: pdr_port_dir_tb.sv
`timescale 1ns/1ps

module pdr_port_dir_tb;
	logic                           clk = 1'b0;
	logic                           resetn = 1'b0;
	logic                           ce = 1'b1;
	pdr_pkg::pdr_req_t              req = '0;
	logic [7:0]                     rdata_r;
	logic                           rvalid_r;
	logic                           rhit_r;
	logic [pdr_pkg::NPORT-1:0][7:0] pin_oe_n;
	logic [15:0]                    a;
	logic [7:0]                     m;
	int                             bad_count = 0;
	int                             n_compared = 0;

	// Free running clock
	initial forever #5 clk = ~clk;

	pdr_port_dir pdr_port_dir_i (.clk(clk), .resetn(resetn), .ce(ce), .req(req), .rdata_r(rdata_r),
		.rvalid_r(rvalid_r), .rhit_r(rhit_r), .pin_oe_n(pin_oe_n));

	// Compare and count
	task chk(input logic [7:0] s, input logic [7:0] e);
		n_compared++;
		if (s !== e)
		begin
			bad_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask

	// One request over one rising edge, held until the next call replaces it
	task op(input logic [15:0] ad, input logic r, input logic wb, input logic wt, input logic [2:0] s,
		input logic v, input logic [7:0] d);
		req = '{ad, r, wb, wt, s, v, d};
		@(negedge clk);
	endtask

	// Drop the request and let one edge pass
	task idle;
		req = '0;
		@(negedge clk);
	endtask

	// Read and check answer of the next cycle
	task rd(input logic [15:0] ad, input logic [7:0] e, input logic h);
		op(ad, 1'b1, 1'b0, 1'b0, 3'h0, 1'b0, 8'h00);
		chk({7'h00, rvalid_r}, 8'h01);
		chk({7'h00, rhit_r}, {7'h00, h});
		chk(rdata_r, e);
	endtask

	// Verdict
	task final_report;
		$display("compared %0d bad %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// Main sequence
	initial
	begin
		repeat (12) @(negedge clk);
		resetn = 1'b1;
		for (int p = 0; p < pdr_pkg::NPORT; p++)
		begin
			a = pdr_pkg::OFFSETS[p];
			m = pdr_pkg::IMPL_MASKS[p];
			rd(a, 8'hff, 1'b1);
			chk(pin_oe_n[p], 8'hff);
			for (int b = 0; b < 8; b++)
			begin
				op(a, 1'b0, 1'b1, 1'b0, 3'h0, 1'b0, ~m);
				op(a, 1'b0, 1'b0, 1'b1, b[2:0], 1'b1, 8'h00);
				chk(pin_oe_n[p], ~m | (8'h01 << b));
				op(a, 1'b0, 1'b1, 1'b0, 3'h0, 1'b0, 8'hff);
				op(a, 1'b0, 1'b0, 1'b1, b[2:0], ~m[b], 8'h00);
				chk(pin_oe_n[p], ~(m & (8'h01 << b)));
			end
			op(a, 1'b0, 1'b1, 1'b0, 3'h0, 1'b0, ~m);
			rd(a, ~m, 1'b1);
			chk(pin_oe_n[p], ~m);
			op(a, 1'b1, 1'b1, 1'b0, 3'h0, 1'b0, 8'hff);
			chk(rdata_r, ~m);
			chk(pin_oe_n[p], 8'hff);
		end
		// Frozen while clock enable is low
		ce = 1'b0;
		op(pdr_pkg::OFFSETS[0], 1'b0, 1'b1, 1'b0, 3'h0, 1'b0, 8'hf3);
		ce = 1'b1;
		chk(pin_oe_n[0], 8'hff);
		// Unmapped address between ports 4 and 10
		op(16'hff25, 1'b0, 1'b1, 1'b0, 3'h0, 1'b0, 8'h00);
		rd(16'hff25, pdr_pkg::UNMAPPED_DATA, 1'b0);
		chk(pin_oe_n[3], 8'hff);
		// Second reset in mid-run
		op(pdr_pkg::OFFSETS[8], 1'b0, 1'b1, 1'b0, 3'h0, 1'b0, 8'hf0);
		chk(pin_oe_n[8], 8'hf0);
		idle;
		resetn = 1'b0;
		@(negedge clk);
		resetn = 1'b1;
		chk(pin_oe_n[8], 8'hff);
		final_report;
	end
endmodule // pdr_port_dir_tb
